// File: bench/alu_model.sv
`timescale 1ns/10ps
`default_nettype none
module alu_model (
	input  wire logic                    clock,
	input  wire logic                    go,
	input  wire logic [15:0]             opA,
	input  wire logic [15:0]             opB,
	output var  cpu_regs_pkg::aluFlags_s aluFlags
);
	// ----------------------------------------------------------------
	// word adder; never touches the debug bit
	// ----------------------------------------------------------------
	logic [16:0] sum;
	assign sum = {1'b0, opA} + {1'b0, opB};
	initial aluFlags = '0;
	// one result pulse per go
	always @(posedge clock)
	begin
		aluFlags.en <= go;
		aluFlags.width <= cpu_regs_pkg::W_WORD;
		aluFlags.result <= {16'h0000, sum[15:0]};
		aluFlags.carry <= sum[16];
		aluFlags.overflow <= (opA[15] == opB[15]) && (sum[15] != opA[15]);
		aluFlags.updCarry <= 1'b1;
		aluFlags.updZero <= 1'b1;
		aluFlags.updSign <= 1'b1;
		aluFlags.updOverflow <= 1'b1;
	end
endmodule
`default_nettype wire

// File: bench/regfile_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module regfile_asserts (
	input wire logic                    clock,
	input wire logic                    rstn,
	input wire cpu_regs_pkg::axiReq_s   axiReq,
	input wire cpu_regs_pkg::axiRsp_s   axiRsp,
	input wire cpu_regs_pkg::cpuWrite_s cpuWrite,
	input wire cpu_regs_pkg::aluFlags_s aluFlags,
	input wire logic [19:0]             pc,
	input wire logic [15:0]             staticBase,
	input wire logic [19:0]             vectorBase,
	input wire logic [10:0]             flags
);
	// ----------------------------------------------------------------
	// bus handshakes and register updates
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	sequence s_wr_taken;
		axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready;
	endsequence
	sequence s_resp_up;
		!axiRsp.bvalid ##1 axiRsp.bvalid;
	endsequence
	a_write_resp: assert property (s_wr_taken |=> s_resp_up)
		else $error("write response not on time");
	a_bresp_hold: assert property (
		axiRsp.bvalid && !axiReq.bready |=> axiRsp.bvalid && $stable(axiRsp.bresp))
		else $error("write response dropped early");
	a_read_answer: assert property (
		axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid && !axiRsp.arready)
		else $error("read answer not on time");
	a_rdata_hold: assert property (
		axiRsp.rvalid && !axiReq.rready |=> axiRsp.rvalid && $stable(axiRsp.rdata))
		else $error("read data not held");
	a_seq_pointer: assert property (
		cpuWrite.en && cpuWrite.sel == cpu_regs_pkg::SEL_PC |=> pc == $past(cpuWrite.data[19:0]))
		else $error("next instruction pointer not loaded");
	a_seq_static: assert property (
		cpuWrite.en && cpuWrite.sel == cpu_regs_pkg::SEL_SB
		|=> staticBase == $past(cpuWrite.data[15:0]))
		else $error("static base not loaded");
	a_seq_vector: assert property (
		cpuWrite.en && cpuWrite.sel == cpu_regs_pkg::SEL_VTB
		|=> vectorBase == $past(cpuWrite.data[19:0]))
		else $error("vector base not loaded");
	a_carry_capture: assert property (
		aluFlags.en && aluFlags.updCarry |=> flags[0] == $past(aluFlags.carry))
		else $error("carry not captured");
	a_zero_word: assert property (
		aluFlags.en && aluFlags.updZero && aluFlags.width == cpu_regs_pkg::W_WORD
		|=> flags[2] == ($past(aluFlags.result[15:0]) == 16'h0000))
		else $error("zero flag wrong");
	a_sign_word: assert property (
		aluFlags.en && aluFlags.updSign && aluFlags.width == cpu_regs_pkg::W_WORD
		|=> flags[3] == $past(aluFlags.result[15]))
		else $error("sign flag wrong");
	a_ovfl_capture: assert property (
		aluFlags.en && aluFlags.updOverflow |=> flags[5] == $past(aluFlags.overflow))
		else $error("overflow not captured");
endmodule
bind cpu_core_register_file regfile_asserts u_regfile_asserts (.clock(clock), .rstn(rstn),
	.axiReq(axiReq), .axiRsp(axiRsp), .cpuWrite(cpuWrite), .aluFlags(aluFlags), .pc(pc),
	.staticBase(staticBase), .vectorBase(vectorBase), .flags(flags));
`default_nettype wire

// File: bench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	// ----------------------------------------------------------------
	// signals and reference model
	// ----------------------------------------------------------------
	logic                    clock = 1'b0;
	logic                    rstn = 1'b0;
	logic                    go = 1'b0;
	logic [15:0]             opA = 16'h0000;
	logic [15:0]             opB = 16'h0000;
	cpu_regs_pkg::axiReq_s   axiReq = '0;
	cpu_regs_pkg::cpuWrite_s cpuWrite = '0;
	cpu_regs_pkg::regSel_e   cpuRdSel = cpu_regs_pkg::SEL_DATA0;
	cpu_regs_pkg::axiRsp_s   axiRsp;
	cpu_regs_pkg::aluFlags_s aluFlags;
	logic [31:0]             cpuRdData;
	logic [15:0]             activeSp;
	logic [15:0]             frameBase;
	logic [15:0]             staticBase;
	logic [19:0]             vectorBase;
	logic [19:0]             pc;
	logic [10:0]             flags;
	logic [31:0]             rd;
	logic [1:0]              rsp;
	int                      miscompares = 0;
	int                      comparisons = 0;
	int                      m [0:31];
	int                      wl [6] = '{7, 8, 11, 14, 15, 16};
	int                      av [4] = '{0, 32'h8000, 32'h7FFF, 32'hFFFF};
	int                      bv [4] = '{0, 32'h8000, 1, 1};
	cpu_core_register_file u_cpu_core_register_file (.clock(clock), .rstn(rstn),
		.axiReq(axiReq), .axiRsp(axiRsp), .cpuWrite(cpuWrite), .cpuRdSel(cpuRdSel),
		.aluFlags(aluFlags), .cpuRdData(cpuRdData), .activeSp(activeSp), .frameBase(frameBase),
		.staticBase(staticBase), .vectorBase(vectorBase), .pc(pc), .flags(flags));
	alu_model u_alu_model (.clock(clock), .go(go), .opA(opA), .opB(opB), .aluFlags(aluFlags));
	// 25 MHz clock
	initial forever #20 clock = ~clock;
	// banked words live at index plus 16 in bank one
	function automatic int key(int i);
		return (i < 7) ? i + 16 * m[12][4] : i;
	endfunction
	function automatic logic [31:0] mask(int i);
		return (i == 7 || i == 8) ? 32'h000FFFFF : (i == 12) ? 32'h000007FF : 32'h0000FFFF;
	endfunction
	function automatic void pair(int lo, int hi, logic [31:0] v);
		m[key(lo)] = v[15:0];
		m[key(hi)] = v[31:16];
	endfunction
	function automatic void mwrite(int i, logic [31:0] v);
		case (i)
			13: m[m[12][7] ? 10 : 9] = v & mask(i);
			14: pair(0, 2, v);
			15: pair(1, 3, v);
			16: pair(4, 5, v);
			default: m[key(i)] = v & mask(i);
		endcase
	endfunction
	function automatic logic [31:0] expect_rd(int i);
		case (i)
			13: return m[12][7] ? m[10] : m[9];
			14: return {m[key(2)][15:0], m[key(0)][15:0]};
			15: return {m[key(3)][15:0], m[key(1)][15:0]};
			16: return {m[key(5)][15:0], m[key(4)][15:0]};
			default: return m[key(i)];
		endcase
	endfunction
	// ----------------------------------------------------------------
	// reporting
	// ----------------------------------------------------------------
	task automatic wrap_up();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic limit(input int n);
		if (n >= 50)
		begin
			miscompares++;
			$display("Error at %0t: handshake timeout", $time);
			wrap_up();
		end
	endtask
	// ----------------------------------------------------------------
	// bus and sequencer drivers
	// ----------------------------------------------------------------
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		int n;
		n = 0;
		axiReq.awvalid <= 1'b1;
		axiReq.awaddr <= a;
		axiReq.wvalid <= 1'b1;
		axiReq.wdata <= v;
		axiReq.wstrb <= 4'hF;
		axiReq.bready <= 1'b1;
		do
		begin
			@(posedge clock);
			n++;
			if (axiRsp.awready)
				axiReq.awvalid <= 1'b0;
			if (axiRsp.wready)
				axiReq.wvalid <= 1'b0;
		end
		while (!axiRsp.bvalid && n < 50);
		limit(n);
		check(axiRsp.bresp, er);
		axiReq.bready <= 1'b0;
		@(posedge clock);
	endtask
	task automatic axi_rd(input logic [7:0] a);
		int n;
		n = 0;
		axiReq.arvalid <= 1'b1;
		axiReq.araddr <= a;
		axiReq.rready <= 1'b1;
		do
		begin
			@(posedge clock);
			n++;
			if (axiRsp.arready)
				axiReq.arvalid <= 1'b0;
		end
		while (!axiRsp.rvalid && n < 50);
		limit(n);
		rd = axiRsp.rdata;
		rsp = axiRsp.rresp;
		axiReq.rready <= 1'b0;
		@(posedge clock);
	endtask
	task automatic wr_bus(input int i, input logic [31:0] v);
		axi_wr(8'(i * 4), v, cpu_regs_pkg::RESP_OKAY);
		mwrite(i, v);
	endtask
	task automatic rd_all();
		for (int i = 0; i < 17; i++)
		begin
			axi_rd(8'(i * 4));
			check(rd, expect_rd(i));
			check(rsp, cpu_regs_pkg::RESP_OKAY);
		end
	endtask
	task automatic outs();
		check(pc, m[8]);
		check(vectorBase, m[7]);
		check(staticBase, m[11]);
		check(flags, m[12]);
		check(activeSp, expect_rd(13));
		check(frameBase, m[key(6)]);
	endtask
	task automatic seq_wr(input int i, input int z, input logic [31:0] v);
		int k;
		k = key(i);
		cpuWrite <= '{1'b1, cpu_regs_pkg::regSel_e'(i), cpu_regs_pkg::wrSize_e'(z), v};
		@(posedge clock);
		cpuWrite.en <= 1'b0;
		@(posedge clock);
		if (z == 1)
			m[k] = {m[k][15:8], v[7:0]};
		else if (z == 2)
			m[k] = {v[15:8], m[k][7:0]};
		else
			mwrite(i, v);
	endtask
	task automatic seq_chk(input int i);
		cpuRdSel <= cpu_regs_pkg::regSel_e'(i);
		repeat (2) @(posedge clock);
		#1 check(cpuRdData, expect_rd(i));
	endtask
	task automatic alu_op(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] s;
		s = {1'b0, a} + {1'b0, b};
		opA <= a;
		opB <= b;
		go <= 1'b1;
		@(posedge clock);
		go <= 1'b0;
		repeat (2) @(posedge clock);
		m[12][0] = s[16];
		m[12][2] = (s[15:0] == 16'h0000);
		m[12][3] = s[15];
		m[12][5] = (a[15] == b[15]) && (s[15] != a[15]);
		#1 check(flags, m[12]);
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		void'($urandom(32'h93B7F88B));
		repeat (6) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		rd_all();
		axi_rd(8'h44);
		check(rd, 32'h00000000);
		check(rsp, cpu_regs_pkg::RESP_SLVERR);
		$display("test reset done");
		for (int i = 0; i < 17; i++)
			wr_bus(i, $urandom & ((i == 12) ? 32'h000007FD : 32'hFFFFFFFF));
		rd_all();
		outs();
		$display("test bus words done");
		axi_wr(8'h44, $urandom, cpu_regs_pkg::RESP_SLVERR);
		rd_all();
		$display("test unmapped done");
		for (int i = 0; i < 6; i++)
		begin
			seq_wr(i % 2, i / 2, $urandom);
			seq_chk(i % 2);
		end
		foreach (wl[j])
			seq_wr(wl[j], 0, $urandom);
		for (int i = 0; i < 17; i++)
			seq_chk(i);
		outs();
		$display("test sequencer done");
		for (int b = 0; b < 2; b++)
		begin
			wr_bus(12, m[12] ^ 32'h10);
			wr_bus(0, $urandom);
			rd_all();
			outs();
		end
		for (int s = 0; s < 2; s++)
		begin
			wr_bus(12, m[12] ^ 32'h80);
			outs();
		end
		$display("test bank and stack done");
		for (int i = 0; i < 24; i++)
			alu_op(16'((i < 4) ? av[i] : $urandom), 16'((i < 4) ? bv[i] : $urandom));
		$display("test flags done");
		wrap_up();
	end
endmodule
`default_nettype wire

// File: core/cpu_core_register_file.sv
// Notes on behaviour
// - four 16-bit general data words
// - data zero and one split into bytes
// - data three:one and two:zero form 32-bit pairs
// - two 16-bit pointer words, also operands
// - pointer one:zero form a 32-bit pair
// - 16-bit frame base for frame-relative addressing
// - 20-bit vector table base register
// - 20-bit next instruction pointer
// - user and interrupt stack, stack flag selects
// - 16-bit static base register
// - 11-bit flag register shows cpu state
// - carry flag captures alu carry or shift-out
// - zero flag set on zero result
// - sign flag set on negative result
// - bank flag picks register bank zero or one
// - overflow flag follows operation overflow
`timescale 1ns/10ps
`default_nettype none
module cpu_core_register_file (
	input  wire logic                    clock,
	input  wire logic                    rstn,
	input  wire cpu_regs_pkg::axiReq_s   axiReq,
	output var  cpu_regs_pkg::axiRsp_s   axiRsp,
	input  wire cpu_regs_pkg::cpuWrite_s cpuWrite,
	input  wire cpu_regs_pkg::regSel_e   cpuRdSel,
	input  wire cpu_regs_pkg::aluFlags_s aluFlags,
	output var  logic [31:0]             cpuRdData,
	output var  logic [15:0]             activeSp,
	output var  logic [15:0]             frameBase,
	output var  logic [15:0]             staticBase,
	output var  logic [19:0]             vectorBase,
	output var  logic [19:0]             pc,
	output var  logic [10:0]             flags
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0][3:0][15:0] dataBank;
		logic [1:0][1:0][15:0] ptrBank;
		logic [1:0][15:0]      fbBank;
		logic [19:0]           vectorBase;
		logic [19:0]           pc;
		logic [15:0]           userSp;
		logic [15:0]           intSp;
		logic [15:0]           staticBase;
		logic [10:0]           flags;
		logic [15:0]           activeSp;
		logic [15:0]           frameBase;
		logic [31:0]           cpuRdData;
		logic                  awGot;
		logic                  wGot;
		logic [7:0]            awAddr;
		logic [31:0]           wData;
		logic [3:0]            wStrb;
		logic                  awReady;
		logic                  wReady;
		logic                  bValid;
		logic [1:0]            bResp;
		logic                  arReady;
		logic                  rValid;
		logic [31:0]           rData;
		logic [1:0]            rResp;
	} regFile_s;

	regFile_s state_r;
	regFile_s state_nxt;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------

	// byte-lane merge of a 16-bit word
	function automatic logic [15:0] merge16(
		input logic [15:0] old,
		input logic [15:0] val,
		input logic [1:0]  strb
	);
		logic [15:0] res;
		res = old;
		for (int i = 0; i < 2; i++)
		begin
			if (strb[i])
				res[i*8 +: 8] = val[i*8 +: 8]; // untouched lane kept
		end
		return res;
	endfunction

	// byte-lane merge of a 32-bit word
	function automatic logic [31:0] merge32(
		input logic [31:0] old,
		input logic [31:0] val,
		input logic [3:0]  strb
	);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				res[i*8 +: 8] = val[i*8 +: 8];
		end
		return res;
	endfunction

	// bus address to register select
	function automatic cpu_regs_pkg::addrHit_s decode(input logic [7:0] addr);
		cpu_regs_pkg::addrHit_s h;
		h.hit = 1'b1;
		h.sel = cpu_regs_pkg::SEL_DATA0;
		case (addr)
			cpu_regs_pkg::OFF_DATA0: h.sel = cpu_regs_pkg::SEL_DATA0;
			cpu_regs_pkg::OFF_DATA1: h.sel = cpu_regs_pkg::SEL_DATA1;
			cpu_regs_pkg::OFF_DATA2: h.sel = cpu_regs_pkg::SEL_DATA2;
			cpu_regs_pkg::OFF_DATA3: h.sel = cpu_regs_pkg::SEL_DATA3;
			cpu_regs_pkg::OFF_PTR0:  h.sel = cpu_regs_pkg::SEL_PTR0;
			cpu_regs_pkg::OFF_PTR1:  h.sel = cpu_regs_pkg::SEL_PTR1;
			cpu_regs_pkg::OFF_FB:    h.sel = cpu_regs_pkg::SEL_FB;
			cpu_regs_pkg::OFF_VTB:   h.sel = cpu_regs_pkg::SEL_VTB;
			cpu_regs_pkg::OFF_PC:    h.sel = cpu_regs_pkg::SEL_PC;
			cpu_regs_pkg::OFF_USP:   h.sel = cpu_regs_pkg::SEL_USP;
			cpu_regs_pkg::OFF_ISP:   h.sel = cpu_regs_pkg::SEL_ISP;
			cpu_regs_pkg::OFF_SB:    h.sel = cpu_regs_pkg::SEL_SB;
			cpu_regs_pkg::OFF_FLG:   h.sel = cpu_regs_pkg::SEL_FLG;
			cpu_regs_pkg::OFF_SP:    h.sel = cpu_regs_pkg::SEL_SP;
			cpu_regs_pkg::OFF_DPLO:  h.sel = cpu_regs_pkg::SEL_DPLO;
			cpu_regs_pkg::OFF_DPHI:  h.sel = cpu_regs_pkg::SEL_DPHI;
			cpu_regs_pkg::OFF_PPAIR: h.sel = cpu_regs_pkg::SEL_PPAIR;
			default:                 h.hit = 1'b0;
		endcase
		return h;
	endfunction

	// read one register from the current bank
	function automatic logic [31:0] readReg(
		input regFile_s              s,
		input cpu_regs_pkg::regSel_e sel
	);
		logic        b;
		logic [31:0] v;
		b = s.flags[cpu_regs_pkg::FLG_BANK]; // bank picked per access
		v = 32'h00000000;
		case (sel)
			cpu_regs_pkg::SEL_DATA0: v = {16'h0000, s.dataBank[b][0]};
			cpu_regs_pkg::SEL_DATA1: v = {16'h0000, s.dataBank[b][1]};
			cpu_regs_pkg::SEL_DATA2: v = {16'h0000, s.dataBank[b][2]};
			cpu_regs_pkg::SEL_DATA3: v = {16'h0000, s.dataBank[b][3]};
			cpu_regs_pkg::SEL_PTR0:  v = {16'h0000, s.ptrBank[b][0]};
			cpu_regs_pkg::SEL_PTR1:  v = {16'h0000, s.ptrBank[b][1]};
			cpu_regs_pkg::SEL_FB:    v = {16'h0000, s.fbBank[b]};
			cpu_regs_pkg::SEL_VTB:   v = {12'h000, s.vectorBase};
			cpu_regs_pkg::SEL_PC:    v = {12'h000, s.pc};
			cpu_regs_pkg::SEL_USP:   v = {16'h0000, s.userSp};
			cpu_regs_pkg::SEL_ISP:   v = {16'h0000, s.intSp};
			cpu_regs_pkg::SEL_SB:    v = {16'h0000, s.staticBase};
			cpu_regs_pkg::SEL_FLG:   v = {21'h000000, s.flags};
			cpu_regs_pkg::SEL_SP:    v = {16'h0000, s.activeSp};
			cpu_regs_pkg::SEL_DPLO:  v = {s.dataBank[b][2], s.dataBank[b][0]};
			cpu_regs_pkg::SEL_DPHI:  v = {s.dataBank[b][3], s.dataBank[b][1]};
			cpu_regs_pkg::SEL_PPAIR: v = {s.ptrBank[b][1], s.ptrBank[b][0]};
			default:                 v = 32'h00000000;
		endcase
		return v;
	endfunction

	// write one register of the current bank through byte strobes
	function automatic regFile_s writeReg(
		input regFile_s              s,
		input cpu_regs_pkg::regSel_e sel,
		input logic [31:0]           d,
		input logic [3:0]            strb
	);
		regFile_s    r;
		logic        b;
		logic [31:0] w;
		r = s;
		b = s.flags[cpu_regs_pkg::FLG_BANK]; // no copy between banks
		w = 32'h00000000;
		case (sel)
			cpu_regs_pkg::SEL_DATA0:
				r.dataBank[b][0] = merge16(s.dataBank[b][0], d[15:0], strb[1:0]);
			cpu_regs_pkg::SEL_DATA1:
				r.dataBank[b][1] = merge16(s.dataBank[b][1], d[15:0], strb[1:0]);
			cpu_regs_pkg::SEL_DATA2:
				r.dataBank[b][2] = merge16(s.dataBank[b][2], d[15:0], strb[1:0]);
			cpu_regs_pkg::SEL_DATA3:
				r.dataBank[b][3] = merge16(s.dataBank[b][3], d[15:0], strb[1:0]);
			cpu_regs_pkg::SEL_PTR0:
				r.ptrBank[b][0] = merge16(s.ptrBank[b][0], d[15:0], strb[1:0]);
			cpu_regs_pkg::SEL_PTR1:
				r.ptrBank[b][1] = merge16(s.ptrBank[b][1], d[15:0], strb[1:0]);
			cpu_regs_pkg::SEL_FB:
				r.fbBank[b] = merge16(s.fbBank[b], d[15:0], strb[1:0]);
			cpu_regs_pkg::SEL_VTB:
			begin
				w = merge32({12'h000, s.vectorBase}, d, strb);
				r.vectorBase = w[19:0];
			end
			cpu_regs_pkg::SEL_PC:
			begin
				w = merge32({12'h000, s.pc}, d, strb);
				r.pc = w[19:0];
			end
			cpu_regs_pkg::SEL_USP:
				r.userSp = merge16(s.userSp, d[15:0], strb[1:0]);
			cpu_regs_pkg::SEL_ISP:
				r.intSp = merge16(s.intSp, d[15:0], strb[1:0]);
			cpu_regs_pkg::SEL_SB:
				r.staticBase = merge16(s.staticBase, d[15:0], strb[1:0]);
			cpu_regs_pkg::SEL_FLG:
			begin
				w = merge32({21'h000000, s.flags}, d, strb); // debug bit stored as written
				r.flags = w[10:0];
			end
			cpu_regs_pkg::SEL_SP:
			begin
				if (s.flags[cpu_regs_pkg::FLG_STACK])
					r.intSp = merge16(s.intSp, d[15:0], strb[1:0]);
				else
					r.userSp = merge16(s.userSp, d[15:0], strb[1:0]);
			end
			cpu_regs_pkg::SEL_DPLO:
			begin
				r.dataBank[b][0] = merge16(s.dataBank[b][0], d[15:0], strb[1:0]);
				r.dataBank[b][2] = merge16(s.dataBank[b][2], d[31:16], strb[3:2]);
			end
			cpu_regs_pkg::SEL_DPHI:
			begin
				r.dataBank[b][1] = merge16(s.dataBank[b][1], d[15:0], strb[1:0]);
				r.dataBank[b][3] = merge16(s.dataBank[b][3], d[31:16], strb[3:2]);
			end
			cpu_regs_pkg::SEL_PPAIR:
			begin
				r.ptrBank[b][0] = merge16(s.ptrBank[b][0], d[15:0], strb[1:0]);
				r.ptrBank[b][1] = merge16(s.ptrBank[b][1], d[31:16], strb[3:2]);
			end
			default:
				r = s;
		endcase
		return r;
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------

	// bus slave, sequencer write, alu flags, derived outputs
	always_comb
	begin
		cpu_regs_pkg::addrHit_s rdHit;
		cpu_regs_pkg::addrHit_s wrHit;
		logic [3:0]             cpuStrb;
		logic                   resZero;
		logic                   resSign;
		state_nxt = state_r;
		rdHit = decode(axiReq.araddr);
		wrHit = decode(state_r.awAddr);
		cpuStrb = 4'hF;
		resZero = 1'b0;
		resSign = 1'b0;

		// read channel: one word per request
		if (axiReq.arvalid && state_r.arReady)
		begin
			state_nxt.rValid = 1'b1;
			state_nxt.rData = rdHit.hit ? readReg(state_r, rdHit.sel) : 32'h00000000;
			state_nxt.rResp = rdHit.hit ? cpu_regs_pkg::RESP_OKAY : cpu_regs_pkg::RESP_SLVERR;
		end
		else if (state_r.rValid && axiReq.rready)
			state_nxt.rValid = 1'b0;

		// write address and data, taken in either order
		if (axiReq.awvalid && state_r.awReady)
		begin
			state_nxt.awGot = 1'b1;
			state_nxt.awAddr = axiReq.awaddr;
		end
		if (axiReq.wvalid && state_r.wReady)
		begin
			state_nxt.wGot = 1'b1;
			state_nxt.wData = axiReq.wdata;
			state_nxt.wStrb = axiReq.wstrb;
		end

		// commit once both halves are held
		if (state_r.awGot && state_r.wGot)
		begin
			if (wrHit.hit)
				state_nxt = writeReg(state_nxt, wrHit.sel, state_r.wData, state_r.wStrb);
			state_nxt.bValid = 1'b1;
			state_nxt.bResp = wrHit.hit ? cpu_regs_pkg::RESP_OKAY : cpu_regs_pkg::RESP_SLVERR;
			state_nxt.awGot = 1'b0;
			state_nxt.wGot = 1'b0;
		end
		else if (state_r.bValid && axiReq.bready)
			state_nxt.bValid = 1'b0;

		// sequencer write, after the bus so it wins a collision
		if (cpuWrite.size == cpu_regs_pkg::SZ_LOW_BYTE)
			cpuStrb = 4'h1;
		else if (cpuWrite.size == cpu_regs_pkg::SZ_HIGH_BYTE)
			cpuStrb = 4'h2;
		if (cpuWrite.sel != cpu_regs_pkg::SEL_DATA0 && cpuWrite.sel != cpu_regs_pkg::SEL_DATA1)
			cpuStrb = 4'hF; // only data zero and one split
		if (cpuWrite.en)
			state_nxt = writeReg(state_nxt, cpuWrite.sel, cpuWrite.data, cpuStrb);

		// result tests by operand width
		case (aluFlags.width)
			cpu_regs_pkg::W_BYTE:
			begin
				resZero = (aluFlags.result[7:0] == 8'h00);
				resSign = aluFlags.result[7];
			end
			cpu_regs_pkg::W_WORD:
			begin
				resZero = (aluFlags.result[15:0] == 16'h0000);
				resSign = aluFlags.result[15];
			end
			default:
			begin
				resZero = (aluFlags.result == 32'h00000000);
				resSign = aluFlags.result[31];
			end
		endcase

		// alu flag updates last, so hardware beats a same-cycle write
		if (aluFlags.en)
		begin
			if (aluFlags.updCarry)
				state_nxt.flags[cpu_regs_pkg::FLG_CARRY] = aluFlags.carry;
			if (aluFlags.updZero)
				state_nxt.flags[cpu_regs_pkg::FLG_ZERO] = resZero;
			if (aluFlags.updSign)
				state_nxt.flags[cpu_regs_pkg::FLG_SIGN] = resSign;
			if (aluFlags.updOverflow)
				state_nxt.flags[cpu_regs_pkg::FLG_OVFL] = aluFlags.overflow;
		end

		// handshake readies from the settled holders
		state_nxt.awReady = !state_nxt.awGot && !state_nxt.bValid;
		state_nxt.wReady = !state_nxt.wGot && !state_nxt.bValid;
		state_nxt.arReady = !state_nxt.rValid;

		// registered views for the sequencer
		state_nxt.cpuRdData = readReg(state_r, cpuRdSel);
		state_nxt.activeSp = state_nxt.flags[cpu_regs_pkg::FLG_STACK] ?
			state_nxt.intSp : state_nxt.userSp;
		state_nxt.frameBase = state_nxt.fbBank[state_nxt.flags[cpu_regs_pkg::FLG_BANK]];
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------

	// synchronous reset to documented-style defaults
	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			state_r <= '0;
			state_r.dataBank <= {8{cpu_regs_pkg::RST_WORD}};
			state_r.ptrBank <= {4{cpu_regs_pkg::RST_WORD}};
			state_r.fbBank <= {2{cpu_regs_pkg::RST_WORD}};
			state_r.vectorBase <= cpu_regs_pkg::RST_LONG;
			state_r.pc <= cpu_regs_pkg::RST_LONG;
			state_r.userSp <= cpu_regs_pkg::RST_WORD;
			state_r.intSp <= cpu_regs_pkg::RST_WORD;
			state_r.staticBase <= cpu_regs_pkg::RST_WORD;
			state_r.flags <= cpu_regs_pkg::RST_FLAGS;
			state_r.activeSp <= cpu_regs_pkg::RST_WORD;
			state_r.frameBase <= cpu_regs_pkg::RST_WORD;
			state_r.awReady <= 1'b1;
			state_r.wReady <= 1'b1;
			state_r.arReady <= 1'b1;
		end
		else
			state_r <= state_nxt;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------

	// every output taken straight from the state register
	assign axiRsp.awready = state_r.awReady;
	assign axiRsp.wready = state_r.wReady;
	assign axiRsp.bvalid = state_r.bValid;
	assign axiRsp.bresp = state_r.bResp;
	assign axiRsp.arready = state_r.arReady;
	assign axiRsp.rvalid = state_r.rValid;
	assign axiRsp.rdata = state_r.rData;
	assign axiRsp.rresp = state_r.rResp;
	assign cpuRdData = state_r.cpuRdData;
	assign activeSp = state_r.activeSp;
	assign frameBase = state_r.frameBase;
	assign staticBase = state_r.staticBase;
	assign vectorBase = state_r.vectorBase;
	assign pc = state_r.pc;
	assign flags = state_r.flags;

endmodule
`default_nettype wire

// File: core/cpu_regs_pkg.sv
`default_nettype none
package cpu_regs_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int AXI_ADDR_W = 8;
	localparam int WORD_W     = 16;
	localparam int LONG_W     = 20;
	localparam int FLAG_W     = 11;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_DATA0 = 8'h00;
	localparam logic [7:0] OFF_DATA1 = 8'h04;
	localparam logic [7:0] OFF_DATA2 = 8'h08;
	localparam logic [7:0] OFF_DATA3 = 8'h0C;
	localparam logic [7:0] OFF_PTR0  = 8'h10;
	localparam logic [7:0] OFF_PTR1  = 8'h14;
	localparam logic [7:0] OFF_FB    = 8'h18;
	localparam logic [7:0] OFF_VTB   = 8'h1C;
	localparam logic [7:0] OFF_PC    = 8'h20;
	localparam logic [7:0] OFF_USP   = 8'h24;
	localparam logic [7:0] OFF_ISP   = 8'h28;
	localparam logic [7:0] OFF_SB    = 8'h2C;
	localparam logic [7:0] OFF_FLG   = 8'h30;
	localparam logic [7:0] OFF_SP    = 8'h34;
	localparam logic [7:0] OFF_DPLO  = 8'h38;
	localparam logic [7:0] OFF_DPHI  = 8'h3C;
	localparam logic [7:0] OFF_PPAIR = 8'h40;

	// ----------------------------------------------------------------
	// flag bit positions and reset values
	// ----------------------------------------------------------------
	localparam int FLG_CARRY = 0;
	localparam int FLG_DEBUG = 1;
	localparam int FLG_ZERO  = 2;
	localparam int FLG_SIGN  = 3;
	localparam int FLG_BANK  = 4;
	localparam int FLG_OVFL  = 5;
	localparam int FLG_IEN   = 6;
	localparam int FLG_STACK = 7;
	localparam logic [15:0] RST_WORD  = 16'h0000;
	localparam logic [19:0] RST_LONG  = 20'h00000;
	localparam logic [10:0] RST_FLAGS = 11'h000;
	localparam logic [1:0]  RESP_OKAY = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		SEL_DATA0, SEL_DATA1, SEL_DATA2, SEL_DATA3, SEL_PTR0, SEL_PTR1, SEL_FB,
		SEL_VTB, SEL_PC, SEL_USP, SEL_ISP, SEL_SB, SEL_FLG, SEL_SP,
		SEL_DPLO, SEL_DPHI, SEL_PPAIR
	} regSel_e;
	typedef enum logic [1:0] {SZ_WORD, SZ_LOW_BYTE, SZ_HIGH_BYTE} wrSize_e;
	typedef enum logic [1:0] {W_BYTE, W_WORD, W_LONG} aluWidth_e;

	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} axiReq_s;
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axiRsp_s;
	typedef struct packed {
		logic        en;
		regSel_e     sel;
		wrSize_e     size;
		logic [31:0] data;
	} cpuWrite_s;
	typedef struct packed {
		logic        en;
		aluWidth_e   width;
		logic [31:0] result;
		logic        carry;
		logic        overflow;
		logic        updCarry;
		logic        updZero;
		logic        updSign;
		logic        updOverflow;
	} aluFlags_s;
	typedef struct packed {
		logic    hit;
		regSel_e sel;
	} addrHit_s;

endpackage
`default_nettype wire
